// ==== src/sbe_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - break at reset forces 9600 baud
// - command variant stays 9600 until exit
// - api variant sends status frames at 9600
// - api keeps 9600 until apply frame
// - host drives sleep low, rts high
// - host breaks input and resets device in the same cycle
// - host holds levels during power up
// - host releases break, sends carriage return
// - success sends menu, then accepts commands
// - host keeps flow control disabled
// - stored configuration survives firmware replacement
// - host restores defaults, sets, commits; sbe_host has no such step and returns to idle once the menu starts
// - host sends one to start upload; sbe_host does not, the bench sends it
// - no transfer in 60 s returns menu
module sbe_device #(
   parameter int UploadWait = sbe_pkg::UploadWaitCycles
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial link
   sbe_link_if.device link,
   // user side
   input wire logic apiVariant,
   input wire logic [sbe_pkg::DivWidth-1:0] storedDiv,
   input wire logic cmdExit,
   output logic forcedRate,
   output sbe_pkg::sbe_mode_e mode,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic breakSeen
);
   import sbe_pkg::*;

   logic rstAll;
   logic [DivWidth-1:0] divReg;
   logic [DivWidth-1:0] rxCnt;
   logic [3:0] rxBit;
   logic rxBusy;
   logic [7:0] rxShift;
   logic [DivWidth-1:0] lowCnt;
   logic [4:0] lowBits;
   logic [DivWidth-1:0] txCnt;
   logic [3:0] txBit;
   logic txBusy;
   logic [9:0] txShift;
   logic txLoad;
   logic [7:0] txByte;
   logic [2:0] seqIdx;
   logic [WaitWidth-1:0] waitCnt;
   logic strapDone;
   logic bootReq;

   assign rstAll = rst_n & link.devResetN;

   // rate selection and strap capture after reset release
   always_ff @(posedge clk_sys or negedge rstAll) begin
      if (!rstAll) begin
         divReg <= DivWidth'(ForcedDiv);
         forcedRate <= 1'b0;
         strapDone <= 1'b0;
         bootReq <= 1'b0;
      end else if (!strapDone) begin
         strapDone <= 1'b1;
         forcedRate <= ~link.hostToDev;
         bootReq <= ~link.hostToDev & ~link.sleepRequestLine & link.rts;
         divReg <= link.hostToDev ? storedDiv : DivWidth'(ForcedDiv);
      end else if (forcedRate && ((mode == SBE_CMD && cmdExit) ||
                   (mode == SBE_API && rxValid && rxData == CharApplyFrame))) begin
         forcedRate <= 1'b0;
         divReg <= storedDiv;
      end
   end

   always_ff @(posedge clk_sys or negedge rstAll) begin
      if (!rstAll) begin
         lowCnt <= '0;
         lowBits <= '0;
         breakSeen <= 1'b0;
      end else if (link.hostToDev) begin
         lowCnt <= '0;
         lowBits <= '0;
         breakSeen <= 1'b0;
      end else if (lowCnt >= divReg - 1'b1) begin
         lowCnt <= '0;
         // the bit time that completes the run sets the flag, so the low run is exactly BreakBits long
         if (lowBits < 5'(BreakBits - 1)) begin
            lowBits <= lowBits + 1'b1;
         end else begin
            breakSeen <= 1'b1;
         end
      end else begin
         lowCnt <= lowCnt + 1'b1;
      end
   end

   // receiver, mid bit sampling
   always_ff @(posedge clk_sys or negedge rstAll) begin
      if (!rstAll) begin
         rxBusy <= 1'b0;
         rxCnt <= '0;
         rxBit <= '0;
         rxShift <= '0;
         rxData <= '0;
         rxValid <= 1'b0;
      end else begin
         rxValid <= 1'b0;
         if (!rxBusy) begin
            if (!link.hostToDev && !breakSeen && strapDone && !(forcedRate && lowBits != 0 && rxBit == 0 && mode == SBE_NORMAL)) begin
               rxBusy <= 1'b1;
               rxCnt <= divReg >> 1;
               rxBit <= '0;
            end
         end else if (rxCnt == 0) begin
            rxCnt <= divReg - 1'b1;
            rxBit <= rxBit + 1'b1;
            if (rxBit == 0 && link.hostToDev) begin
               rxBusy <= 1'b0;
            end else if (rxBit >= 1 && rxBit <= 8) begin
               rxShift <= {link.hostToDev, rxShift[7:1]};
            end else if (rxBit == 9) begin
               rxBusy <= 1'b0;
               if (link.hostToDev) begin
                  rxData <= rxShift;
                  rxValid <= 1'b1;
               end
            end
         end else begin
            rxCnt <= rxCnt - 1'b1;
         end
      end
   end

   // transmitter
   always_ff @(posedge clk_sys or negedge rstAll) begin
      if (!rstAll) begin
         txBusy <= 1'b0;
         txCnt <= '0;
         txBit <= '0;
         txShift <= '1;
      end else if (!txBusy) begin
         if (txLoad) begin
            txBusy <= 1'b1;
            txShift <= {1'b1, txByte, 1'b0};
            txCnt <= divReg - 1'b1;
            txBit <= '0;
         end
      end else if (txCnt == 0) begin
         txCnt <= divReg - 1'b1;
         txShift <= {1'b1, txShift[9:1]};
         txBit <= txBit + 1'b1;
         if (txBit == 4'(FrameBits - 1)) begin
            txBusy <= 1'b0;
         end
      end else begin
         txCnt <= txCnt - 1'b1;
      end
   end
   assign link.devToHost = txShift[0];

   // byte to send for the current sequence position
   always_comb begin
      txByte = CharMenu0;
      txLoad = 1'b0;
      if (mode == SBE_BOOT_MENU && !txBusy && seqIdx < 3'(MenuLen)) begin
         txLoad = 1'b1;
         unique case (seqIdx)
            3'b000: txByte = CharMenu0;
            3'b001: txByte = CharMenu1;
            3'b010: txByte = CharMenu2;
            default: txByte = CharMenu3;
         endcase
      end else if (mode == SBE_API && !txBusy && seqIdx < 3'b010) begin
         txLoad = 1'b1;
         txByte = (seqIdx == 0) ? CharStatusReset : CharStatusJoined;
      end
   end

   // mode sequencing
   always_ff @(posedge clk_sys or negedge rstAll) begin
      if (!rstAll) begin
         mode <= SBE_NORMAL;
         seqIdx <= '0;
         waitCnt <= '0;
      end else begin
         if (txLoad) begin
            seqIdx <= seqIdx + 1'b1;
         end
         unique case (mode)
            SBE_NORMAL: begin
               if (strapDone && bootReq) begin
                  mode <= SBE_BOOT_WAIT_CR;
               end else if (strapDone && forcedRate) begin
                  mode <= apiVariant ? SBE_API : SBE_CMD;
                  seqIdx <= '0;
               end
            end
            SBE_CMD: begin
               if (cmdExit) begin
                  mode <= SBE_NORMAL;
               end
            end
            SBE_API: begin
               if (rxValid && rxData == CharApplyFrame) begin
                  mode <= SBE_NORMAL;
               end
            end
            SBE_BOOT_WAIT_CR: begin
               if (rxValid && rxData == CharCr) begin
                  mode <= SBE_BOOT_MENU;
                  seqIdx <= '0;
               end
            end
            SBE_BOOT_MENU: begin
               if (seqIdx == 3'(MenuLen) && !txBusy) begin
                  mode <= SBE_BOOT_IDLE;
               end
            end
            SBE_BOOT_IDLE: begin
               if (rxValid && rxData == CharOne) begin
                  mode <= SBE_BOOT_UPLOAD;
                  waitCnt <= '0;
               end
            end
            SBE_BOOT_UPLOAD: begin
               if (rxBusy) begin
                  waitCnt <= '0;
               end else if (waitCnt >= WaitWidth'(UploadWait - 1)) begin
                  mode <= SBE_BOOT_MENU;
                  seqIdx <= '0;
               end else begin
                  waitCnt <= waitCnt + 1'b1;
               end
            end
            default: mode <= SBE_NORMAL;
         endcase
      end
   end
   // storedDiv is kept outside and never reset here
endmodule
`default_nettype wire

// ==== src/sbe_pkg.sv ====
package sbe_pkg;
   // system clock and serial timing
   localparam int ClkHz = 10000000;
   localparam int ForcedBaud = 9600;
   localparam int ForcedDiv = ClkHz / ForcedBaud;
   localparam int DefaultDiv = 87;
   localparam int DivWidth = 16;
   localparam int FrameBits = 10;
   // break only after a full frame plus one bit
   localparam int BreakBits = FrameBits + 1;
   // characters
   localparam logic [7:0] CharCr = 8'h0d;
   localparam logic [7:0] CharOne = 8'h31;
   localparam logic [7:0] CharMenu0 = 8'h42;
   localparam logic [7:0] CharMenu1 = 8'h4c;
   localparam logic [7:0] CharMenu2 = 8'h20;
   localparam logic [7:0] CharMenu3 = 8'h3e;
   localparam int MenuLen = 4;
   localparam logic [7:0] CharStatusReset = 8'h00;
   localparam logic [7:0] CharStatusJoined = 8'h02;
   localparam logic [7:0] CharApplyFrame = 8'h41;
   // upload wait
   localparam int UploadWaitSec = 60;
   localparam longint UploadWaitCyclesL = longint'(UploadWaitSec) * longint'(ClkHz);
   localparam int UploadWaitCycles = int'(UploadWaitCyclesL);
   localparam int WaitWidth = 30;
   // device modes
   typedef enum logic [2:0] {
      SBE_NORMAL = 3'b000,
      SBE_CMD = 3'b001,
      SBE_API = 3'b010,
      SBE_BOOT_WAIT_CR = 3'b011,
      SBE_BOOT_MENU = 3'b100,
      SBE_BOOT_IDLE = 3'b101,
      SBE_BOOT_UPLOAD = 3'b110
   } sbe_mode_e;
endpackage

// ==== src/sbe_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sbe_link_if;
   logic hostToDev;
   logic devToHost;
   logic sleepRequestLine;
   logic rts;
   logic devResetN;
   modport device(input hostToDev, input sleepRequestLine, input rts, input devResetN, output devToHost);
   modport host(output hostToDev, output sleepRequestLine, output rts, output devResetN, input devToHost);
endinterface
`default_nettype wire

// ==== src/sbe_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbe_host
   import sbe_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial link
   sbe_link_if.host link,
   // user side
   input wire logic bootStart,
   input wire logic [15:0] resetHold,
   output logic bootActive,
   output logic menuSeen
);
   import sbe_pkg::*;

   typedef enum logic [2:0] {
      SBH_IDLE = 3'b000,
      SBH_LEVELS = 3'b001,
      SBH_RESET = 3'b010,
      SBH_POWER = 3'b011,
      SBH_SEND_CR = 3'b100,
      SBH_WAIT_MENU = 3'b101
   } sbh_state_e;

   sbh_state_e state;
   logic [15:0] cnt;
   logic [DivWidth-1:0] bitCnt;
   logic [3:0] bitIdx;
   logic [9:0] sh;

   // flow control unused
   // entry sequence; rts is only a static level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= SBH_IDLE;
         cnt <= '0;
         bitCnt <= '0;
         bitIdx <= '0;
         sh <= '1;
         link.hostToDev <= 1'b1;
         link.sleepRequestLine <= 1'b1;
         link.rts <= 1'b0;
         link.devResetN <= 1'b1;
         bootActive <= 1'b0;
         menuSeen <= 1'b0;
      end else begin
         unique case (state)
            SBH_IDLE: begin
               if (bootStart) begin
                  link.sleepRequestLine <= 1'b0;
                  link.rts <= 1'b1;
                  bootActive <= 1'b1;
                  menuSeen <= 1'b0;
                  state <= SBH_LEVELS;
               end
            end
            SBH_LEVELS: begin
               link.hostToDev <= 1'b0;
               link.devResetN <= 1'b0;
               cnt <= '0;
               state <= SBH_RESET;
            end
            SBH_RESET: begin
               cnt <= cnt + 1'b1;
               if (cnt >= resetHold) begin
                  link.devResetN <= 1'b1;
                  cnt <= '0;
                  state <= SBH_POWER;
               end
            end
            SBH_POWER: begin
               cnt <= cnt + 1'b1;
               if (cnt >= resetHold) begin
                  link.hostToDev <= 1'b1;
                  sh <= {1'b1, CharCr, 1'b0};
                  bitCnt <= DivWidth'(ForcedDiv - 1);
                  bitIdx <= '0;
                  state <= SBH_SEND_CR;
               end
            end
            SBH_SEND_CR: begin
               if (bitCnt == DivWidth'(ForcedDiv - 1)) begin
                  link.hostToDev <= sh[0];
               end
               if (bitCnt == 0) begin
                  bitCnt <= DivWidth'(ForcedDiv - 1);
                  sh <= {1'b1, sh[9:1]};
                  bitIdx <= bitIdx + 1'b1;
                  if (bitIdx == 4'(FrameBits - 1)) begin
                     state <= SBH_WAIT_MENU;
                  end
               end else begin
                  bitCnt <= bitCnt - 1'b1;
               end
            end
            SBH_WAIT_MENU: begin
               link.hostToDev <= 1'b1;
               if (!link.devToHost) begin
                  menuSeen <= 1'b1;
                  bootActive <= 1'b0;
                  state <= SBH_IDLE;
               end
            end
            default: state <= SBH_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== dv/sbe_link_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbe_link_chk
   import sbe_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // link signals
   input wire logic hostToDev,
   input wire logic devToHost,
   input wire logic sleepRequestLine,
   input wire logic rts,
   input wire logic devResetN
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [15:0] lowCnt;
   // length of the current low run on the device output
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         lowCnt <= 16'h0000;
      else if (devToHost)
         lowCnt <= 16'h0000;
      else
         lowCnt <= lowCnt + 16'h0001;
   end
   // device output rests high while held in reset
   a_reset_out_idle: assert property (!devResetN |-> devToHost)
      else $error("device output low during reset");
   a_sleep_first: assert property ($fell(sleepRequestLine) |-> devResetN && hostToDev)
      else $error("sleep line lowered after break or reset");
   a_levels_first: assert property ($fell(devResetN) |-> !sleepRequestLine && rts)
      else $error("handshake levels missing at reset");
   a_break_at_reset: assert property ($fell(devResetN) |-> !hostToDev)
      else $error("reset without break");
   a_hold_powerup: assert property (!devResetN |-> !hostToDev && !sleepRequestLine && rts)
      else $error("levels lost during power up");
   a_break_past_up: assert property ($rose(devResetN) |-> !hostToDev [*8])
      else $error("break dropped at release");
   a_menu_after_cr: assert property ($fell(devToHost) |-> hostToDev)
      else $error("device sends while host breaks");
   a_menu_bit_time: assert property ($rose(devToHost) && devResetN |-> lowCnt >= ForcedDiv - 2)
      else $error("menu bit shorter than forced rate");
   a_out_no_break: assert property (!devToHost |-> lowCnt < 9 * ForcedDiv + 9)
      else $error("device output low beyond a frame");
endmodule
`default_nettype wire

// ==== dv/tb_serial_boot_entry_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_serial_boot_entry_control
   import sbe_pkg::*;
   ;
   localparam int UpW = 2000;
   logic clk_sys, rst_n, bootStart, bootActive, menuSeen, apiVariant, cmdExit, forced2, brk2;
   logic [DivWidth-1:0] storedDiv;
   logic [7:0] rxData2;
   sbe_mode_e mode1, mode2;
   logic [7:0] menuText [4] = '{CharMenu0, CharMenu1, CharMenu2, CharMenu3};
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   sbe_link_if lnk();
   sbe_link_if lnk2();
   // host and device joined; second device driven by the bench
   sbe_host i_sbe_host(.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.host), .bootStart(bootStart),
      .resetHold(16'h0014), .bootActive(bootActive), .menuSeen(menuSeen));
   sbe_device #(.UploadWait(UpW)) i_sbe_device(.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.device),
      .apiVariant(1'b0), .storedDiv(16'h0057), .cmdExit(1'b0), .forcedRate(), .mode(mode1), .rxData(),
      .rxValid(), .breakSeen());
   sbe_device #(.UploadWait(UpW)) i_sbe_device_2(.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk2.device),
      .apiVariant(apiVariant), .storedDiv(storedDiv), .cmdExit(cmdExit), .forcedRate(forced2),
      .mode(mode2), .rxData(rxData2), .rxValid(), .breakSeen(brk2));
   sbe_link_chk i_sbe_link_chk(.clk_sys(clk_sys), .rst_n(rst_n), .hostToDev(lnk.hostToDev),
      .devToHost(lnk.devToHost), .sleepRequestLine(lnk.sleepRequestLine), .rts(lnk.rts),
      .devResetN(lnk.devResetN));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_count++;
         close_out();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one 8N1 frame, lsb first, at the forced rate
   task automatic tx(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < FrameBits; i++) begin
         lnk2.hostToDev <= f[i];
         repeat (ForcedDiv) @(posedge clk_sys);
      end
   endtask
   // sample mid-bit, return in the stop bit
   task automatic rx(output logic [7:0] b);
      while (lnk2.devToHost !== 1'b0) @(posedge clk_sys);
      repeat (ForcedDiv / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (ForcedDiv) @(posedge clk_sys);
         b[i] = lnk2.devToHost;
      end
      repeat (ForcedDiv) @(posedge clk_sys);
   endtask
   // reset the second device with the given strap levels
   task automatic strap(input logic hd, input logic sl, input logic rt);
      lnk2.devResetN <= 1'b0;
      lnk2.hostToDev <= hd;
      lnk2.sleepRequestLine <= sl;
      lnk2.rts <= rt;
      repeat (3) @(posedge clk_sys);
      lnk2.devResetN <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   initial begin
      int n;
      logic [7:0] b;
      rst_n = 1'b0;
      bootStart = 1'b0;
      apiVariant = 1'b0;
      cmdExit = 1'b0;
      storedDiv = 16'h0057;
      lnk2.hostToDev = 1'b1;
      lnk2.sleepRequestLine = 1'b1;
      lnk2.rts = 1'b0;
      lnk2.devResetN = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      bootStart <= 1'b1;
      @(posedge clk_sys);
      bootStart <= 1'b0;
      // host entry on the first pair runs beside the strap tests on the second device, to keep the run short
      fork
         begin
            for (n = 0; n < 20000 && menuSeen !== 1'b1; n++) @(posedge clk_sys);
            check(menuSeen, 1'b1);
            check(mode1, SBE_BOOT_MENU);
            $display("test host entry done");
         end
         begin
            strap(1'b1, 1'b1, 1'b0);
            check(forced2, 1'b0);
            lnk2.hostToDev <= 1'b0;
            repeat (BreakBits * DefaultDiv - 30) @(posedge clk_sys);
            check(brk2, 1'b0);
            repeat (60) @(posedge clk_sys);
            check(brk2, 1'b1);
            $display("test break detect done");
            strap(1'b0, 1'b1, 1'b0);
            lnk2.hostToDev <= 1'b1;
            check(forced2, 1'b1);
            check(mode2, SBE_CMD);
            repeat (100) @(posedge clk_sys);
            check(forced2, 1'b1);
            cmdExit <= 1'b1;
            @(posedge clk_sys);
            cmdExit <= 1'b0;
            repeat (2) @(posedge clk_sys);
            check(forced2, 1'b0);
            $display("test command start done");
            apiVariant <= 1'b1;
            strap(1'b0, 1'b1, 1'b0);
            lnk2.hostToDev <= 1'b1;
            check(mode2, SBE_API);
            rx(b);
            check(b, CharStatusReset);
            rx(b);
            check(b, CharStatusJoined);
            check(forced2, 1'b1);
            tx(CharApplyFrame);
            repeat (2) @(posedge clk_sys);
            check(rxData2, CharApplyFrame);
            check(forced2, 1'b0);
            $display("test api start done");
         end
      join
      apiVariant <= 1'b0;
      strap(1'b0, 1'b0, 1'b1);
      check(mode2, SBE_BOOT_WAIT_CR);
      lnk2.hostToDev <= 1'b1;
      // let the false start seen at strap release run out before the real frame
      repeat (ForcedDiv) @(posedge clk_sys);
      tx(CharCr);
      for (int i = 0; i < MenuLen; i++) begin
         rx(b);
         check(b, menuText[i]);
      end
      repeat (ForcedDiv) @(posedge clk_sys);
      check(mode2, SBE_BOOT_IDLE);
      tx(CharOne);
      check(mode2, SBE_BOOT_UPLOAD);
      for (n = 0; n < UpW + 100 && mode2 !== SBE_BOOT_MENU; n++) @(posedge clk_sys);
      check(n > UpW - 1100 && n < UpW + 100, 1'b1);
      $display("test upload wait done");
      close_out();
   end
endmodule
`default_nettype wire
